// *** wfd_regs.svh ***
// Register offsets, field positions, reset values and counts for wake frame detection
`ifndef WFD_REGS_SVH
`define WFD_REGS_SVH

// Control and status register fields
`define WFD_CSR_PATTERN_EN_BIT   1
`define WFD_CSR_FRAME_EN_BIT     2
`define WFD_CSR_PATTERN_RCV_BIT  5
`define WFD_CSR_FRAME_RCV_BIT    6
`define WFD_CSR_NOTIFY_PME_BIT   8
`define WFD_CSR_LOAD_PTR_LSB     16
`define WFD_CSR_RESET            32'h0000_0000

// Filter load port word sequence
`define WFD_LOAD_WORDS           8
`define WFD_LOAD_CMD_WORD        4
`define WFD_LOAD_OFFSET_WORD     5
`define WFD_LOAD_CRC01_WORD      6
`define WFD_LOAD_CRC23_WORD      7
`define WFD_CMD_ENABLE_BIT       0
`define WFD_CMD_MCAST_BIT        3
`define WFD_MASK_RESET           32'h0000_0000

// Frame layout and pattern packet counts
`define WFD_ADDR_FIELDS_LEN      12
`define WFD_DA_LEN               6
`define WFD_MASK_BYTES           31
`define WFD_SYNC_LEN             6
`define WFD_ADDR_REPS            16
`define WFD_SYNC_BYTE            8'hff

// CRC-16 engine
`define WFD_CRC_INIT             16'hffff
`define WFD_CRC_POLY_REFL        16'ha001

`endif

// *** wfd_pkg.sv ***
// Types shared by the wake frame detection modules
package wfd_pkg;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } wfd_rx_byte_t;

  typedef struct packed {
    logic [31:0] mask;
    logic [3:0]  cmd;
    logic [7:0]  offset;
    logic [15:0] crc;
  } wfd_filter_cfg_t;

  typedef enum logic [1:0] {
    WFD_SEARCH_SYNC,
    WFD_AFTER_SYNC,
    WFD_MATCH_ADDR
  } wfd_state_t;

  // CRC-16 over one byte, bit 0 first, reflected polynomial
  function automatic logic [15:0] wfd_crc16_byte(input logic [15:0] crc_in,
                                                 input logic [7:0]  data);
    logic [15:0] c;
    c = crc_in;
    for (int b = 0; b < 8; b++) begin
      if (c[0] ^ data[b]) begin
        c = (c >> 1) ^ 16'ha001;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : wfd_crc16_byte

endpackage : wfd_pkg

// *** wfd_filter.sv ***
// One programmable wake frame filter: masked CRC-16 and command check
`include "wfd_regs.svh"
module wfd_filter
  import wfd_pkg::*;
(
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // Receive byte stream
  input  wire wfd_rx_byte_t    rx,
  input  wire logic [10:0]     rx_index,
  input  wire logic            frame_mcast,
  // Configuration
  input  wire wfd_filter_cfg_t cfg,
  // Result, valid with the last byte of a frame
  output logic                 match
);

  logic [15:0] crc;
  logic [15:0] base_crc;
  logic [15:0] next_crc;
  logic [10:0] rel;
  logic        in_window;

  always_comb begin
    base_crc  = rx.sof ? `WFD_CRC_INIT : crc;
    rel       = rx_index - {3'h0, cfg.offset};
    in_window = (rx_index >= {3'h0, cfg.offset}) && (rel < 11'(`WFD_MASK_BYTES)) // R4
                && cfg.mask[rel[4:0]];                                           // R1
    next_crc  = in_window ? wfd_crc16_byte(base_crc, rx.data) : base_crc;       // R22
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc <= `WFD_CRC_INIT;
    end else if (rx.valid) begin
      crc <= next_crc;
    end
  end

  assign match = rx.valid && rx.eof
                 && cfg.cmd[`WFD_CMD_ENABLE_BIT]                 // R3
                 && (cfg.cmd[`WFD_CMD_MCAST_BIT] == frame_mcast) // R2
                 && (next_crc == cfg.crc);                       // R6

endmodule : wfd_filter

// *** wfd_core.sv ***
// Wake frame and wake pattern packet detection for the receive path
`include "wfd_regs.svh"

// How it works
// R1 - Mask bit j includes byte offset plus j
// R2 - Address type picks multicast or unicast frames
// R3 - Command enable bit turns filter on
// R4 - Offset indexes frame from destination byte zero
// R5 - Software keeps offset at twelve or more
// R6 - Equal CRC-16 means wake frame received
// R7 - Pattern enable blocks reception, scans data
// R8 - Pattern match notifies by interrupt or event
// R9 - Pattern match sets pattern received flag
// R10 - Clearing pattern enable resumes normal reception
// R11 - Candidates addressed to station or broadcast
// R12 - Multicast frames also accepted as candidates
// R13 - Search six all-ones bytes after addresses
// R14 - Sixteen back-to-back station address copies required
// R15 - Broken run restarts the sync search
// R16 - Sync and copies may start anywhere
// R17 - D1 state forces both detections on
// R18 - Four independent programmable filters
// R19 - Filter pass sets frame flag, notifies
// R20 - Software loads filters with eight writes
// R21 - Broadcast wakes despite broadcast disable bit
// R22 - Both sides share one CRC-16 form
module wfd_core
  import wfd_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Receive byte stream from the MAC receive path
  input  wire wfd_rx_byte_t rx,
  // Station address, byte 0 is the first on the wire
  input  wire logic [47:0]  station_addr,
  // Power state and broadcast control from the MAC
  input  wire logic         power_state_d1,
  input  wire logic         broadcast_disable,
  // Control and status register port
  input  wire logic         csr_wr,
  input  wire logic [31:0]  csr_wdata,
  output logic [31:0]       csr_rdata,
  // Filter load port
  input  wire logic         wake_filter_load_port_wr,
  input  wire logic [31:0]  wake_filter_load_port_wdata,
  // Receive control and host notification
  output logic              rx_block,
  output logic              host_irq,
  output logic              power_event_output
);

  localparam int NF = 4;

  // Control and status bits
  logic            wake_pattern_enable;
  logic            wake_frame_enable;
  logic            notify_pme;
  logic            wake_pattern_received_flag;
  logic            wake_frame_received_flag;

  // Filter storage
  logic [31:0]     mask_q [NF];
  logic [3:0]      cmd_q [NF];
  logic [7:0]      offset_q [NF];
  logic [15:0]     crc_q [NF];
  logic [2:0]      load_ptr;
  wfd_filter_cfg_t cfg [NF];
  logic [NF-1:0]   filter_hit;

  // Frame tracking
  logic [10:0]     byte_cnt;
  logic [10:0]     rx_index;
  logic            da_mcast;
  logic            da_station;
  logic            cur_mcast;
  logic            cur_station;
  logic            addr_ok;

  // Pattern packet search
  wfd_state_t      state;
  wfd_state_t      next_state;
  logic [2:0]      sync_cnt;
  logic [2:0]      next_sync_cnt;
  logic [2:0]      addr_byte;
  logic [2:0]      next_addr_byte;
  logic [3:0]      rep_cnt;
  logic [3:0]      next_rep_cnt;
  logic            pattern_found;

  logic            pattern_active;
  logic            frame_active;
  logic            frame_event;
  logic            clr_pattern;
  logic            clr_frame;

  function automatic logic [7:0] addr_byte_at(input logic [47:0] addr, input logic [2:0] k);
    return addr[8*k +: 8];
  endfunction : addr_byte_at

  // Detection enables
  assign pattern_active = wake_pattern_enable || power_state_d1; // R17
  assign frame_active   = wake_frame_enable || power_state_d1;   // R17
  assign rx_block       = pattern_active || frame_active;        // R7 R10

  // Control and status register
  assign clr_pattern = csr_wr && csr_wdata[`WFD_CSR_PATTERN_RCV_BIT];
  assign clr_frame   = csr_wr && csr_wdata[`WFD_CSR_FRAME_RCV_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_pattern_enable <= 1'(`WFD_CSR_RESET >> `WFD_CSR_PATTERN_EN_BIT);
      wake_frame_enable   <= 1'(`WFD_CSR_RESET >> `WFD_CSR_FRAME_EN_BIT);
      notify_pme          <= 1'(`WFD_CSR_RESET >> `WFD_CSR_NOTIFY_PME_BIT);
    end else if (csr_wr) begin
      wake_pattern_enable <= csr_wdata[`WFD_CSR_PATTERN_EN_BIT]; // R7 R10
      wake_frame_enable   <= csr_wdata[`WFD_CSR_FRAME_EN_BIT];
      notify_pme          <= csr_wdata[`WFD_CSR_NOTIFY_PME_BIT];
    end
  end

  // Sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_pattern_received_flag <= 1'b0;
    end else if (pattern_found) begin
      wake_pattern_received_flag <= 1'b1; // R9
    end else if (clr_pattern) begin
      wake_pattern_received_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_frame_received_flag <= 1'b0;
    end else if (frame_event) begin
      wake_frame_received_flag <= 1'b1; // R19
    end else if (clr_frame) begin
      wake_frame_received_flag <= 1'b0;
    end
  end

  always_comb begin
    csr_rdata = 32'h0000_0000;
    csr_rdata[`WFD_CSR_PATTERN_EN_BIT]  = wake_pattern_enable;
    csr_rdata[`WFD_CSR_FRAME_EN_BIT]    = wake_frame_enable;
    csr_rdata[`WFD_CSR_PATTERN_RCV_BIT] = wake_pattern_received_flag;
    csr_rdata[`WFD_CSR_FRAME_RCV_BIT]   = wake_frame_received_flag;
    csr_rdata[`WFD_CSR_NOTIFY_PME_BIT]  = notify_pme;
    csr_rdata[`WFD_CSR_LOAD_PTR_LSB +: 3] = load_ptr;
  end

  // Notification follows the sticky flags through the selected output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_irq           <= 1'b0;
      power_event_output <= 1'b0;
    end else begin
      host_irq           <= (wake_pattern_received_flag || wake_frame_received_flag) && !notify_pme; // R8 R19
      power_event_output <= (wake_pattern_received_flag || wake_frame_received_flag) && notify_pme;  // R8 R19
    end
  end

  // Filter load port: eight successive words fill the filter table
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_ptr <= 3'h0;
    end else if (wake_filter_load_port_wr) begin
      load_ptr <= load_ptr + 3'h1; // R20
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NF; i++) begin
        mask_q[i]   <= `WFD_MASK_RESET;
        cmd_q[i]    <= 4'h0;
        offset_q[i] <= 8'h00;
        crc_q[i]    <= 16'h0000;
      end
    end else if (wake_filter_load_port_wr) begin
      unique case (load_ptr)
        3'(`WFD_LOAD_CMD_WORD): begin
          for (int i = 0; i < NF; i++) begin
            cmd_q[i] <= wake_filter_load_port_wdata[8*i +: 4];
          end
        end
        3'(`WFD_LOAD_OFFSET_WORD): begin
          for (int i = 0; i < NF; i++) begin
            offset_q[i] <= wake_filter_load_port_wdata[8*i +: 8];
          end
        end
        3'(`WFD_LOAD_CRC01_WORD): begin
          crc_q[0] <= wake_filter_load_port_wdata[15:0];
          crc_q[1] <= wake_filter_load_port_wdata[31:16];
        end
        3'(`WFD_LOAD_CRC23_WORD): begin
          crc_q[2] <= wake_filter_load_port_wdata[15:0];
          crc_q[3] <= wake_filter_load_port_wdata[31:16];
        end
        default: begin
          mask_q[load_ptr[1:0]] <= {1'b0, wake_filter_load_port_wdata[30:0]}; // R1
        end
      endcase
    end
  end

  // Four filters run side by side on every byte
  for (genvar g = 0; g < NF; g++) begin : g_filter // R18
    assign cfg[g] = '{mask: mask_q[g], cmd: cmd_q[g], offset: offset_q[g], crc: crc_q[g]};
    wfd_filter u_filter (
      .clock       (clock),
      .rst_n       (rst_n),
      .rx          (rx),
      .rx_index    (rx_index),
      .frame_mcast (cur_mcast),
      .cfg         (cfg[g]),
      .match       (filter_hit[g])
    );
  end

  // Byte position and destination address checks
  assign rx_index = rx.sof ? 11'h000 : byte_cnt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt <= 11'h000;
    end else if (rx.valid && rx_index != 11'h7ff) begin
      byte_cnt <= rx_index + 11'h001;
    end
  end

  always_comb begin
    cur_mcast   = (rx_index == 11'h000) ? rx.data[0] : da_mcast;
    cur_station = rx.sof ? 1'b1 : da_station;
    if (rx_index < 11'(`WFD_DA_LEN)) begin
      cur_station = cur_station && (rx.data == addr_byte_at(station_addr, rx_index[2:0]));
    end
    // Broadcast is multicast, so it passes regardless of broadcast_disable
    addr_ok = cur_station || cur_mcast; // R11 R12 R21
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      da_mcast   <= 1'b0;
      da_station <= 1'b0;
    end else if (rx.valid) begin
      da_mcast   <= cur_mcast;
      da_station <= cur_station;
    end
  end

  assign frame_event = frame_active && (|filter_hit) && addr_ok; // R19 R21

  // Pattern packet search
  always_comb begin
    next_state     = state;
    next_sync_cnt  = sync_cnt;
    next_addr_byte = addr_byte;
    next_rep_cnt   = rep_cnt;
    pattern_found  = 1'b0;
    if (rx.sof || rx_index < 11'(`WFD_ADDR_FIELDS_LEN)) begin
      next_state    = WFD_SEARCH_SYNC; // R13
      next_sync_cnt = 3'h0;
    end else begin
      unique case (state)
        WFD_SEARCH_SYNC: begin
          if (rx.data == `WFD_SYNC_BYTE) begin
            next_sync_cnt = sync_cnt + 3'h1;
            if (sync_cnt == 3'(`WFD_SYNC_LEN - 1)) begin
              next_state = WFD_AFTER_SYNC; // R13
            end
          end else begin
            next_sync_cnt = 3'h0;
          end
        end
        WFD_AFTER_SYNC: begin
          if (rx.data == addr_byte_at(station_addr, 3'h0)) begin
            next_state     = WFD_MATCH_ADDR; // R14 R16
            next_addr_byte = 3'h1;
            next_rep_cnt   = 4'h0;
          end else if (rx.data != `WFD_SYNC_BYTE) begin
            next_state    = WFD_SEARCH_SYNC;
            next_sync_cnt = 3'h0;
          end
        end
        WFD_MATCH_ADDR: begin
          if (rx.data == addr_byte_at(station_addr, addr_byte)) begin
            next_addr_byte = addr_byte + 3'h1;
            if (addr_byte == 3'(`WFD_DA_LEN - 1)) begin
              next_addr_byte = 3'h0;
              next_rep_cnt   = rep_cnt + 4'h1;
              if (rep_cnt == 4'(`WFD_ADDR_REPS - 1)) begin
                // Idle bytes between valid ones must never complete a match
                pattern_found = rx.valid && pattern_active && addr_ok; // R8 R9 R11 R12 R14
                next_state    = WFD_SEARCH_SYNC;
                next_sync_cnt = 3'h0;
              end
            end
          end else begin
            // A broken run may itself begin the next sync stream
            next_state    = WFD_SEARCH_SYNC; // R15
            next_sync_cnt = (rx.data == `WFD_SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= WFD_SEARCH_SYNC;
      sync_cnt  <= 3'h0;
      addr_byte <= 3'h0;
      rep_cnt   <= 4'h0;
    end else if (rx.valid && pattern_active) begin
      state     <= next_state;
      sync_cnt  <= next_sync_cnt;
      addr_byte <= next_addr_byte;
      rep_cnt   <= next_rep_cnt;
    end else if (!pattern_active) begin
      state     <= WFD_SEARCH_SYNC; // R10
      sync_cnt  <= 3'h0;
    end
  end

  logic unused_ok;
  assign unused_ok = broadcast_disable;

endmodule : wfd_core

// *** wfd_core_sva.sv ***
// Port checker for the wake frame detection core
module wfd_core_sva
  import wfd_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         rst_n,
  // Receive stream and station
  input wire wfd_rx_byte_t rx,
  input wire logic [47:0]  station_addr,
  input wire logic         power_state_d1,
  // Register ports
  input wire logic         csr_wr,
  input wire logic [31:0]  csr_wdata,
  input wire logic [31:0]  csr_rdata,
  input wire logic         wake_filter_load_port_wr,
  // Outputs to the MAC and host
  input wire logic         rx_block,
  input wire logic         host_irq,
  input wire logic         power_event_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  irq_notify_a: assert property ($rose(csr_rdata[5] | csr_rdata[6]) && !csr_rdata[8] |=> host_irq)
    else $error("host interrupt missing after a received flag");
  event_notify_a: assert property ($rose(csr_rdata[5] | csr_rdata[6]) && csr_rdata[8] |=> power_event_output)
    else $error("power event missing after a received flag");
  quiet_notify_a: assert property (csr_rdata[6:5] == 2'b00 |=> !host_irq && !power_event_output)
    else $error("notify output high without a received flag");
  rx_block_a: assert property (rx_block == (csr_rdata[1] | csr_rdata[2] | power_state_d1))
    else $error("receive block does not follow the enables");
  pattern_gate_a: assert property ($rose(csr_rdata[5]) |-> $past(csr_rdata[1]) || $past(power_state_d1))
    else $error("pattern flag set while pattern detection off");
  frame_gate_a: assert property ($rose(csr_rdata[6]) |-> $past(csr_rdata[2]) || $past(power_state_d1))
    else $error("frame flag set while frame detection off");
  frame_eof_a: assert property ($rose(csr_rdata[6]) |-> $past(rx.valid) && $past(rx.eof))
    else $error("frame flag set away from the last byte");
  pattern_last_a: assert property ($rose(csr_rdata[5]) |-> $past(rx.valid) && $past(rx.data) == station_addr[47:40])
    else $error("pattern flag set away from the last address byte");
  flag_sticky_a: assert property (csr_rdata[5] && !(csr_wr && csr_wdata[5]) |=> csr_rdata[5])
    else $error("pattern flag dropped without a clear");
  enable_write_a: assert property (csr_wr |=> csr_rdata[2:1] == $past(csr_wdata[2:1]) && csr_rdata[8] == $past(csr_wdata[8]))
    else $error("enable bits do not follow the write");
  load_ptr_a: assert property (wake_filter_load_port_wr |=> csr_rdata[18:16] == $past(csr_rdata[18:16]) + 3'h1)
    else $error("load pointer did not advance");
endmodule : wfd_core_sva

bind wfd_core wfd_core_sva wfd_core_sva_i (.clock(clock), .rst_n(rst_n), .rx(rx), .station_addr(station_addr),
  .power_state_d1(power_state_d1), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
  .wake_filter_load_port_wr(wake_filter_load_port_wr), .rx_block(rx_block), .host_irq(host_irq),
  .power_event_output(power_event_output));

// *** wfd_rx_model.sv ***
// Receive path model: streams one stored frame, back to back or with gaps
module wfd_rx_model
  import wfd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [10:0] len,
  output logic             busy,
  // Byte stream
  output wfd_rx_byte_t     rx
);
  logic [7:0]  mem [0:2047];
  logic [10:0] pos;
  logic        gap;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      pos  <= 11'h000;
      gap  <= 1'b0;
      rx   <= '0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      pos  <= 11'h000;
    end else if (busy && (gap || !slow)) begin
      rx   <= '{valid: 1'b1, sof: pos == 11'h000, eof: pos == len - 11'h001, data: mem[pos]};
      pos  <= pos + 11'h001;
      gap  <= 1'b0;
      busy <= pos != len - 11'h001;
    end else begin
      // Idle data flips so a stale byte never repeats
      rx   <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~rx.data};
      gap  <= 1'b1;
    end
  end
endmodule : wfd_rx_model

// *** tb.sv ***
// Self-checking testbench for the wake frame detection core
module tb
  import wfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] msk [4] = '{32'h0000_0005, 32'h4000_0001, 32'h0000_00ff, 32'h7fff_ffff};
  localparam logic [7:0]  ofs [4] = '{8'h0c, 8'h0e, 8'h10, 8'h0d};

  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  wfd_rx_byte_t rx;
  logic [47:0]  station_addr = 48'h5544_3322_1100;
  logic         power_state_d1 = 1'b0;
  logic         broadcast_disable = 1'b1;
  logic         csr_wr = 1'b0;
  logic [31:0]  csr_wdata = 32'h0;
  logic [31:0]  csr_rdata;
  logic         load_wr = 1'b0;
  logic [31:0]  load_wdata = 32'h0;
  logic         rx_block;
  logic         host_irq;
  logic         power_event_output;
  logic         start = 1'b0;
  logic         slow = 1'b0;
  logic [10:0]  len = 11'h000;
  logic         busy;
  logic [7:0]   q [$];
  int           fail_count = 0;
  int           checks_done = 0;

  initial begin
    forever #50 clock = ~clock;
  end

  wfd_core wfd_core_i (.clock(clock), .rst_n(rst_n), .rx(rx), .station_addr(station_addr),
    .power_state_d1(power_state_d1), .broadcast_disable(broadcast_disable), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .wake_filter_load_port_wr(load_wr),
    .wake_filter_load_port_wdata(load_wdata), .rx_block(rx_block), .host_irq(host_irq),
    .power_event_output(power_event_output));
  wfd_rx_model wfd_rx_model_i (.clock(clock), .rst_n(rst_n), .start(start), .slow(slow), .len(len),
    .busy(busy), .rx(rx));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] crc(input logic [7:0] o, input logic [31:0] m);
    logic [15:0] c = 16'hffff;
    for (int j = 0; j < 31; j++) begin
      for (int b = 0; b < 8; b++) begin
        if (m[j]) c = (c[0] ^ q[o + j][b]) ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction : crc

  task automatic csr(input logic [31:0] w);
    @(posedge clock);
    csr_wr    <= 1'b1;
    csr_wdata <= w;
    @(posedge clock);
    csr_wr    <= 1'b0;
    @(negedge clock);
  endtask : csr

  task automatic hdr(input logic [47:0] da);
    q = {};
    for (int k = 0; k < 12; k++) begin
      q.push_back(k < 6 ? da[8*k +: 8] : 8'(8'h20 + k));
    end
  endtask : hdr

  task automatic magic(input int n);
    for (int k = 0; k < 6 + 6 * n; k++) begin
      q.push_back(k < 6 ? 8'hff : station_addr[8*((k - 6) % 6) +: 8]);
    end
  endtask : magic

  task automatic send(input logic s);
    int i = 0;
    foreach (q[k]) wfd_rx_model_i.mem[k] = q[k];
    @(posedge clock);
    start <= 1'b1;
    slow  <= s;
    len   <= 11'(q.size());
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    while (busy && i < 3000) begin
      @(negedge clock);
      i++;
    end
    if (busy) begin
      fail_count++;
      results();
    end
    repeat (3) @(negedge clock);
  endtask : send

  task automatic pcase(input logic [31:0] csrv, input logic [47:0] da, input int pre, n, input logic s, exp);
    csr(csrv);
    check(rx_block, csrv[1]);
    hdr(da);
    q.push_back(8'h07);
    magic(pre);
    q.push_back(8'h99);
    magic(n);
    send(s);
    check(csr_rdata[5], exp);
    check({host_irq, power_event_output}, exp ? (csrv[8] ? 2'b01 : 2'b10) : 2'b00);
    csr(32'h60);
    check({rx_block, csr_rdata[6:5]}, 3'h0);
  endtask : pcase

  task automatic fcase(input logic [3:0] en, mc, bad, input logic [47:0] da, input logic d1, exp);
    logic [31:0] w [8] = '{default: 32'h0};
    hdr(da);
    for (int k = 0; k < 48; k++) begin
      q.push_back(8'(8'h30 + 7 * k));
    end
    for (int i = 0; i < 4; i++) begin
      w[i] = msk[i];
      w[4][8*i +: 4] = {mc[i], 2'b00, en[i]};
      w[5][8*i +: 8] = ofs[i];
      w[6 + i / 2][16 * (i % 2) +: 16] = crc(ofs[i], msk[i]) ^ {15'h0, bad[i]};
    end
    foreach (w[i]) begin
      @(posedge clock);
      load_wr    <= 1'b1;
      load_wdata <= w[i];
    end
    @(posedge clock);
    load_wr        <= 1'b0;
    power_state_d1 <= d1;
    csr(d1 ? 32'h0 : 32'h4);
    check(csr_rdata[18:16], 3'h0);
    check(rx_block, 1'b1);
    send(1'b0);
    check(csr_rdata[6], exp);
    check(host_irq, exp);
    @(posedge clock);
    power_state_d1 <= 1'b0;
    csr(32'h60);
  endtask : fcase

  task automatic t_pattern();
    pcase(32'h002, station_addr, 0, 16, 1'b0, 1'b1);
    pcase(32'h102, {48{1'b1}}, 15, 16, 1'b1, 1'b1);
    $display("test pattern done");
  endtask : t_pattern

  task automatic t_pattern_refuse();
    pcase(32'h002, station_addr, 0, 15, 1'b0, 1'b0);
    pcase(32'h002, 48'h5544_3322_1102, 0, 16, 1'b0, 1'b0);
    pcase(32'h102, 48'h5544_3322_1101, 0, 16, 1'b1, 1'b1);
    pcase(32'h000, station_addr, 0, 16, 1'b0, 1'b0);
    $display("test pattern refuse done");
  endtask : t_pattern_refuse

  task automatic t_filter();
    fcase(4'h1, 4'h0, 4'h0, station_addr, 1'b0, 1'b1);
    fcase(4'h0, 4'h0, 4'h0, station_addr, 1'b0, 1'b0);
    fcase(4'h2, 4'h2, 4'h0, {48{1'b1}}, 1'b0, 1'b1);
    fcase(4'h2, 4'h0, 4'h0, {48{1'b1}}, 1'b0, 1'b0);
    fcase(4'h8, 4'h0, 4'h8, station_addr, 1'b0, 1'b0);
    fcase(4'h8, 4'h0, 4'h0, station_addr, 1'b0, 1'b1);
    fcase(4'h4, 4'h0, 4'h0, station_addr, 1'b1, 1'b1);
    fcase(4'h1, 4'h0, 4'h0, 48'h5544_3322_1102, 1'b0, 1'b0);
    $display("test filter done");
  endtask : t_filter

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_pattern();
    t_pattern_refuse();
    t_filter();
    results();
  end
endmodule : tb
